//--- common/sscie_params.svh
// register map, field positions, reset values and bus codes of the enable control
`ifndef SSCIE_PARAMS_SVH
`define SSCIE_PARAMS_SVH

`define SSCIE_ADDR_SET    32'hf0010044
`define SSCIE_ADDR_CLR    32'hf0010048
`define SSCIE_ADDR_MASK   32'hf001004c
`define SSCIE_ADDR_STATUS 32'hf0010050

`define SSCIE_FIELD_W     12
`define SSCIE_FIELD_VALID 12'hf33

`define SSCIE_BIT_TX_HOLD_FREE  0
`define SSCIE_BIT_TX_ALL_SENT   1
`define SSCIE_BIT_RX_WORD_AVAIL 4
`define SSCIE_BIT_RX_OVERRUN    5
`define SSCIE_BIT_CMP_ZERO      8
`define SSCIE_BIT_CMP_ONE       9
`define SSCIE_BIT_TX_SYNC       10
`define SSCIE_BIT_RX_SYNC       11

`define SSCIE_MASK_RST   12'h000
`define SSCIE_STATUS_RST 12'h000

`define SSCIE_RESP_OKAY   2'b00
`define SSCIE_RESP_SLVERR 2'b10

`endif

//--- common/sscie_pkg.sv
// types and shared decode helpers of the enable control
`include "sscie_params.svh"
package sscie_pkg;

  typedef logic [`SSCIE_FIELD_W-1:0] sscie_field_t;

  typedef enum {
    SSCIE_REG_SET,
    SSCIE_REG_CLR,
    SSCIE_REG_MASK,
    SSCIE_REG_STATUS,
    SSCIE_REG_NONE
  } sscie_reg_t;

  function automatic sscie_reg_t sscie_decode(input logic [31:0] addr);
    case (addr)
      `SSCIE_ADDR_SET:    sscie_decode = SSCIE_REG_SET;
      `SSCIE_ADDR_CLR:    sscie_decode = SSCIE_REG_CLR;
      `SSCIE_ADDR_MASK:   sscie_decode = SSCIE_REG_MASK;
      `SSCIE_ADDR_STATUS: sscie_decode = SSCIE_REG_STATUS;
      default:            sscie_decode = SSCIE_REG_NONE;
    endcase
  endfunction : sscie_decode

  // byte lanes 0 and 1 carry every field; lanes 2 and 3 hold nothing
  function automatic sscie_field_t sscie_lanes(input logic [3:0] strb);
    sscie_lanes = {{4{strb[1]}}, {8{strb[0]}}} & `SSCIE_FIELD_VALID;
  endfunction : sscie_lanes

endpackage : sscie_pkg

//--- logic/sscie_axil_slave.sv
// axi4-lite slave front end turning bus beats into one-cycle strobes
`include "sscie_params.svh"
module sscie_axil_slave
  import sscie_pkg::*;
(
  input  wire logic        i_ref_clk,  // system clock
  input  wire logic        i_sys_rst,  // async reset, high
  input  wire logic        i_awvalid,  // write address valid
  output logic             o_awready,  // write address ready
  input  wire logic [31:0] i_awaddr,   // write address
  input  wire logic        i_wvalid,   // write data valid
  output logic             o_wready,   // write data ready
  input  wire logic [31:0] i_wdata,    // write data
  input  wire logic [3:0]  i_wstrb,    // write byte enables
  output logic             o_bvalid,   // write response valid
  input  wire logic        i_bready,   // write response ready
  output logic [1:0]       o_bresp,    // write response code
  input  wire logic        i_arvalid,  // read address valid
  output logic             o_arready,  // read address ready
  input  wire logic [31:0] i_araddr,   // read address
  output logic             o_rvalid,   // read data valid
  input  wire logic        i_rready,   // read data ready
  output logic [31:0]      o_rdata,    // read data
  output logic [1:0]       o_rresp,    // read response code
  output logic             o_wr_en,    // write strobe
  output logic [31:0]      o_wr_addr,  // held write address
  output logic [31:0]      o_wr_data,  // held write data
  output logic [3:0]       o_wr_strb,  // held byte enables
  input  wire logic        i_wr_err,   // write refused
  output logic             o_rd_en,    // read strobe
  output logic [31:0]      o_rd_addr,  // held read address
  input  wire logic [31:0] i_rd_data,  // read value
  input  wire logic        i_rd_err    // read refused
);

  logic aw_full_reg;
  logic w_full_reg;
  logic ar_full_reg;

  // address and data are held apart so either may arrive first
  assign o_awready = !aw_full_reg && !o_bvalid;
  assign o_wready  = !w_full_reg && !o_bvalid;
  assign o_wr_en   = aw_full_reg && w_full_reg && !o_bvalid;
  assign o_arready = !ar_full_reg && !o_rvalid;
  assign o_rd_en   = ar_full_reg && !o_rvalid;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_full_reg <= 1'b0;
      o_wr_addr   <= 32'h0;
    end else if (i_awvalid && o_awready) begin
      aw_full_reg <= 1'b1;
      o_wr_addr   <= i_awaddr;
    end else if (o_wr_en) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      w_full_reg <= 1'b0;
      o_wr_data  <= 32'h0;
      o_wr_strb  <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_full_reg <= 1'b1;
      o_wr_data  <= i_wdata;
      o_wr_strb  <= i_wstrb;
    end else if (o_wr_en) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= `SSCIE_RESP_OKAY;
    end else if (o_wr_en) begin
      o_bvalid <= 1'b1;
      o_bresp  <= i_wr_err ? `SSCIE_RESP_SLVERR : `SSCIE_RESP_OKAY;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ar_full_reg <= 1'b0;
      o_rd_addr   <= 32'h0;
    end else if (i_arvalid && o_arready) begin
      ar_full_reg <= 1'b1;
      o_rd_addr   <= i_araddr;
    end else if (o_rd_en) begin
      ar_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= `SSCIE_RESP_OKAY;
    end else if (o_rd_en) begin
      o_rvalid <= 1'b1;
      o_rdata  <= i_rd_data;
      o_rresp  <= i_rd_err ? `SSCIE_RESP_SLVERR : `SSCIE_RESP_OKAY;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule : sscie_axil_slave

//--- logic/sscie_ctrl.sv
// interrupt enable set/clear, mask view and sticky status of the serial controller
//
// Operation
// RQ1: set-register bit 0 one enables tx holding free; zero leaves it.
// RQ2: set-register bit 1 one enables tx all sent; zero leaves it.
// RQ3: set-register bit 4 one enables rx word available; zero leaves it.
// RQ4: set-register bit 5 one enables rx overrun; zero leaves it.
// RQ5: set-register compare-0 bit one enables compare zero; zero changes nothing.
// RQ6: set-register bit 9 one enables compare one; zero leaves it.
// RQ7: set-register bit 10 one enables tx sync; zero leaves it.
// RQ8: set-register bit 11 one enables rx sync; zero leaves it.
// RQ9: write-only clear register at f0010048, same field layout as set.
// RQ10: clear-register one disables the matching source; zero does nothing.
// RQ11: read-only mask view at f001004c shows every enable, same layout.
// RQ12: interrupt high while any flagged source is enabled, low otherwise.
// RQ13: mask resets to all disabled; writes update it at the write edge.
`include "sscie_params.svh"
module sscie_ctrl
  import sscie_pkg::*;
(
  input  wire logic                     i_ref_clk,    // 10 MHz clock
  input  wire logic                     i_sys_rst,    // async reset, high
  input  wire logic                     i_awvalid,    // write address valid
  output logic                          o_awready,    // write address ready
  input  wire logic [31:0]              i_awaddr,     // write address
  input  wire logic                     i_wvalid,     // write data valid
  output logic                          o_wready,     // write data ready
  input  wire logic [31:0]              i_wdata,      // write data
  input  wire logic [3:0]               i_wstrb,      // write byte enables
  output logic                          o_bvalid,     // write response valid
  input  wire logic                     i_bready,     // write response ready
  output logic [1:0]                    o_bresp,      // write response code
  input  wire logic                     i_arvalid,    // read address valid
  output logic                          o_arready,    // read address ready
  input  wire logic [31:0]              i_araddr,     // read address
  output logic                          o_rvalid,     // read data valid
  input  wire logic                     i_rready,     // read data ready
  output logic [31:0]                   o_rdata,      // read data
  output logic [1:0]                    o_rresp,      // read response code
  input  wire logic [`SSCIE_FIELD_W-1:0] i_src_events, // source event pulses
  output logic [`SSCIE_FIELD_W-1:0]     o_mask_view,  // current enables
  output logic                          o_irq         // interrupt, high
);

  logic         wr_en;
  logic [31:0]  wr_addr;
  logic [31:0]  wr_data;
  logic [3:0]   wr_strb;
  logic         wr_err;
  logic         rd_en;
  logic [31:0]  rd_addr;
  logic [31:0]  rd_data;
  logic         rd_err;

  sscie_reg_t   wr_hit;
  sscie_reg_t   rd_hit;
  sscie_field_t wr_ones;
  sscie_field_t mask_reg;
  sscie_field_t status_reg;
  logic         wr_set;
  logic         wr_clr;
  logic         rd_status;

  sscie_axil_slave u_bus (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_awaddr  (i_awaddr),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .o_bresp   (o_bresp),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .i_araddr  (i_araddr),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  assign wr_hit    = sscie_decode(wr_addr);
  assign rd_hit    = sscie_decode(rd_addr);
  // only ones on enabled byte lanes act; zeros never touch the mask
  assign wr_ones   = wr_data[`SSCIE_FIELD_W-1:0] & sscie_lanes(wr_strb);
  assign wr_set    = wr_en && (wr_hit == SSCIE_REG_SET);
  assign wr_clr    = wr_en && (wr_hit == SSCIE_REG_CLR);
  assign rd_status = rd_en && (rd_hit == SSCIE_REG_STATUS);

  // the mask view and status are read-only; writing them is refused
  assign wr_err = !(wr_hit == SSCIE_REG_SET || wr_hit == SSCIE_REG_CLR);

  // mask register: one set edge or one clear edge per bus write
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mask_reg <= `SSCIE_MASK_RST; // [RQ13]
    end else if (wr_set) begin
      mask_reg <= mask_reg | wr_ones; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8]
    end else if (wr_clr) begin
      mask_reg <= mask_reg & ~wr_ones; // [RQ9] [RQ10]
    end
  end

  // sticky status; an event in the read-clear cycle survives the clear
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_reg <= `SSCIE_STATUS_RST;
    end else begin
      status_reg <= (rd_status ? `SSCIE_STATUS_RST : status_reg)
                    | (i_src_events & `SSCIE_FIELD_VALID);
    end
  end

  // set and clear registers are write-only and read back as zero
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    case (rd_hit)
      SSCIE_REG_MASK: begin
        rd_data = {{(32-`SSCIE_FIELD_W){1'b0}}, mask_reg}; // [RQ11]
      end
      SSCIE_REG_STATUS: begin
        rd_data = {{(32-`SSCIE_FIELD_W){1'b0}}, status_reg};
      end
      SSCIE_REG_SET, SSCIE_REG_CLR: begin
        rd_data = 32'h0;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  assign o_mask_view = mask_reg;
  // level output; software drops it by reading status or clearing enables
  assign o_irq       = |(status_reg & mask_reg); // [RQ12]

  // checks
  // expectations below use raw bus data and strobes, except a_clr_hits, which uses the lane-helper result wr_ones
  logic [31:0]  mask_word;
  logic         rd_mask;

  assign mask_word    = {{(32-`SSCIE_FIELD_W){1'b0}}, mask_reg};
  assign rd_mask      = rd_en && (rd_hit == SSCIE_REG_MASK);

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_set_tx_hold;
    wr_set |=> mask_reg[`SSCIE_BIT_TX_HOLD_FREE]
               == $past(mask_reg[`SSCIE_BIT_TX_HOLD_FREE]
                        || wr_data[`SSCIE_BIT_TX_HOLD_FREE] && wr_strb[0]);
  endproperty
  a_set_tx_hold: assert property (p_set_tx_hold) // [RQ1]
    else $error("tx holding free enable wrong after set write");

  property p_set_tx_sent;
    wr_set |=> mask_reg[`SSCIE_BIT_TX_ALL_SENT]
               == $past(mask_reg[`SSCIE_BIT_TX_ALL_SENT]
                        || wr_data[`SSCIE_BIT_TX_ALL_SENT] && wr_strb[0]);
  endproperty
  a_set_tx_sent: assert property (p_set_tx_sent) // [RQ2]
    else $error("tx all sent enable wrong after set write");

  property p_set_rx_word;
    wr_set |=> mask_reg[`SSCIE_BIT_RX_WORD_AVAIL]
               == $past(mask_reg[`SSCIE_BIT_RX_WORD_AVAIL]
                        || wr_data[`SSCIE_BIT_RX_WORD_AVAIL] && wr_strb[0]);
  endproperty
  a_set_rx_word: assert property (p_set_rx_word) // [RQ3]
    else $error("rx word available enable wrong after set write");

  property p_set_rx_ovr;
    wr_set |=> mask_reg[`SSCIE_BIT_RX_OVERRUN]
               == $past(mask_reg[`SSCIE_BIT_RX_OVERRUN]
                        || wr_data[`SSCIE_BIT_RX_OVERRUN] && wr_strb[0]);
  endproperty
  a_set_rx_ovr: assert property (p_set_rx_ovr) // [RQ4]
    else $error("rx overrun enable wrong after set write");

  property p_set_cmp0;
    wr_set && wr_strb[1] && wr_data[`SSCIE_BIT_CMP_ZERO]
      |=> mask_reg[`SSCIE_BIT_CMP_ZERO];
  endproperty
  a_set_cmp0: assert property (p_set_cmp0) // [RQ5]
    else $error("compare zero not enabled by set write");

  property p_set_cmp0_keeps;
    wr_set && !(wr_strb[1] && wr_data[`SSCIE_BIT_CMP_ZERO])
      |=> mask_reg[`SSCIE_BIT_CMP_ZERO] == $past(mask_reg[`SSCIE_BIT_CMP_ZERO]);
  endproperty
  a_set_cmp0_keeps: assert property (p_set_cmp0_keeps) // [RQ5]
    else $error("compare zero enable changed by a zero in the set write");

  property p_set_cmp1;
    wr_set |=> mask_reg[`SSCIE_BIT_CMP_ONE]
               == $past(mask_reg[`SSCIE_BIT_CMP_ONE]
                        || wr_data[`SSCIE_BIT_CMP_ONE] && wr_strb[1]);
  endproperty
  a_set_cmp1: assert property (p_set_cmp1) // [RQ6]
    else $error("compare one enable wrong after set write");

  property p_set_tx_sync;
    wr_set |=> mask_reg[`SSCIE_BIT_TX_SYNC]
               == $past(mask_reg[`SSCIE_BIT_TX_SYNC]
                        || wr_data[`SSCIE_BIT_TX_SYNC] && wr_strb[1]);
  endproperty
  a_set_tx_sync: assert property (p_set_tx_sync) // [RQ7]
    else $error("tx sync enable wrong after set write");

  property p_set_rx_sync;
    wr_set |=> mask_reg[`SSCIE_BIT_RX_SYNC]
               == $past(mask_reg[`SSCIE_BIT_RX_SYNC]
                        || wr_data[`SSCIE_BIT_RX_SYNC] && wr_strb[1]);
  endproperty
  a_set_rx_sync: assert property (p_set_rx_sync) // [RQ8]
    else $error("rx sync enable wrong after set write");

  property p_clr_hits;
    wr_en && wr_addr == `SSCIE_ADDR_CLR
      |=> (mask_reg & $past(wr_ones)) == '0 ##0 o_bresp == `SSCIE_RESP_OKAY;
  endproperty
  a_clr_hits: assert property (p_clr_hits) // [RQ9]
    else $error("clear register write did not disable its ones");

  property p_clr_keeps;
    wr_clr |=> mask_reg == $past(mask_reg & ~(wr_data[`SSCIE_FIELD_W-1:0]
                                 & {{4{wr_strb[1]}}, {8{wr_strb[0]}}}));
  endproperty
  a_clr_keeps: assert property (p_clr_keeps) // [RQ10]
    else $error("clear write touched a bit written as zero");

  property p_mask_read;
    rd_mask |=> o_rvalid && o_rdata == $past(mask_word)
                && o_rresp == `SSCIE_RESP_OKAY;
  endproperty
  a_mask_read: assert property (p_mask_read) // [RQ11]
    else $error("mask view read returned wrong value");

  property p_irq_follows;
    (|(i_src_events & mask_reg)) && !wr_clr |=> o_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // [RQ12]
    else $error("enabled event did not raise interrupt");

  property p_irq_quiet;
    mask_reg == '0 |-> !o_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) // [RQ12]
    else $error("interrupt high with every source disabled");

  property p_mask_only_by_write;
    !wr_set && !wr_clr |=> $stable(mask_reg);
  endproperty
  a_mask_only_by_write: assert property (p_mask_only_by_write) // [RQ13]
    else $error("mask changed without a set or clear write");

  property p_write_answer;
    wr_en |=> o_bvalid
              && o_bresp == ($past(wr_addr == `SSCIE_ADDR_SET || wr_addr == `SSCIE_ADDR_CLR)
                             ? `SSCIE_RESP_OKAY : `SSCIE_RESP_SLVERR);
  endproperty
  a_write_answer: assert property (p_write_answer) // [RQ13]
    else $error("write response missing one cycle after strobe");

  property p_write_alone;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  a_write_alone: assert property (p_write_alone) // [RQ13]
    else $error("new write accepted while a response is pending");

  property p_refused_write;
    wr_en && (wr_addr == `SSCIE_ADDR_MASK || wr_addr == `SSCIE_ADDR_STATUS)
      |=> o_bvalid && o_bresp == `SSCIE_RESP_SLVERR && $stable(mask_reg);
  endproperty
  a_refused_write: assert property (p_refused_write) // [RQ11]
    else $error("write to a read-only register was not refused");

  property p_mask_reserved;
    (mask_reg & ~`SSCIE_FIELD_VALID) == '0;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) // [RQ11]
    else $error("mask view shows an unimplemented field");

  property p_read_setclr_zero;
    rd_en && (rd_addr == `SSCIE_ADDR_SET || rd_addr == `SSCIE_ADDR_CLR)
      |=> o_rvalid && o_rdata == '0 && o_rresp == `SSCIE_RESP_OKAY;
  endproperty
  a_read_setclr_zero: assert property (p_read_setclr_zero) // [RQ9]
    else $error("write-only register read back nonzero");

  property p_read_unmapped;
    rd_en && rd_hit == SSCIE_REG_NONE
      |=> o_rvalid && o_rdata == '0 && o_rresp == `SSCIE_RESP_SLVERR;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) // [RQ11]
    else $error("unmapped read not refused");

  property p_read_answer;
    rd_en |=> o_rvalid && !o_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) // [RQ11]
    else $error("read data missing one cycle after strobe");

  property p_status_sticky;
    !rd_status |=> (status_reg & $past(status_reg)) == $past(status_reg);
  endproperty
  a_status_sticky: assert property (p_status_sticky) // [RQ12]
    else $error("status bit dropped without a status read");

  // an event in the read-clear cycle must survive the clear
  property p_status_catches;
    (|(i_src_events & `SSCIE_FIELD_VALID))
      |=> (status_reg & $past(i_src_events & `SSCIE_FIELD_VALID))
          == $past(i_src_events & `SSCIE_FIELD_VALID);
  endproperty
  a_status_catches: assert property (p_status_catches) // [RQ12]
    else $error("source event not latched in status");

  property p_status_read_clear;
    rd_status && i_src_events == '0 |=> status_reg == '0;
  endproperty
  a_status_read_clear: assert property (p_status_read_clear) // [RQ12]
    else $error("status read did not clear status");

  property p_irq_on_set;
    wr_set && !rd_status
      && (|(status_reg & wr_data[`SSCIE_FIELD_W-1:0] & {{4{wr_strb[1]}}, {8{wr_strb[0]}}}))
      |=> o_irq;
  endproperty
  a_irq_on_set: assert property (p_irq_on_set) // [RQ12]
    else $error("enabling a flagged source did not raise interrupt");

endmodule : sscie_ctrl

//--- tb/test_ssc_interrupt_enable_control.sv
// self-checking bench of the interrupt enable control over its axi4-lite port
`include "sscie_params.svh"
module test_ssc_interrupt_enable_control
  import sscie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_ref_clk, i_sys_rst;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp;
  logic [11:0] i_src_events, o_mask_view;
  int          miscompares, cmp_count, cycles, m_mask, m_stat;
  logic [31:0] seed;

  sscie_ctrl i_sscie_ctrl (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_src_events(i_src_events), .o_mask_view(o_mask_view), .o_irq(o_irq)
  );

  always #50 i_ref_clk = ~i_ref_clk;

  // hang guard, far above the fewer than a thousand cycles the tests need
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // lane 0 covers bits 7:0, lane 1 bits 11:8; only implemented fields count
  function automatic int lanes(input logic [3:0] s);
    return ((s[1] ? 32'hf00 : 0) | (s[0] ? 32'hff : 0)) & 32'hf33;
  endfunction : lanes

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic chk_state();
    @(negedge i_ref_clk);
    chk("mask_view", 32'(o_mask_view), m_mask);
    chk("irq", 32'(o_irq), 32'((m_mask & m_stat) != 0));
    @(posedge i_ref_clk);
  endtask : chk_state

  // ready is sampled before the edge so the handshake edge is known exactly
  task automatic axw(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, ad, wd;
    ad = 0;
    wd = 0;
    i_awvalid <= 1'b1;
    i_awaddr  <= a;
    i_wvalid  <= 1'b1;
    i_wdata   <= d;
    i_wstrb   <= s;
    i_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge i_ref_clk);
      ah = i_awvalid && o_awready;
      wh = i_wvalid && o_wready;
      @(posedge i_ref_clk);
      if (ah) begin
        i_awvalid <= 1'b0;
        ad = 1;
      end
      if (wh) begin
        i_wvalid <= 1'b0;
        wd = 1;
      end
    end
    do begin
      @(negedge i_ref_clk);
      ah = o_bvalid;
      r  = o_bresp;
      @(posedge i_ref_clk);
    end while (ah !== 1'b1);
    i_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    i_arvalid <= 1'b1;
    i_araddr  <= a;
    i_rready  <= 1'b1;
    do begin
      @(negedge i_ref_clk);
      h = i_arvalid && o_arready;
      @(posedge i_ref_clk);
    end while (h !== 1'b1);
    i_arvalid <= 1'b0;
    do begin
      @(negedge i_ref_clk);
      h = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_ref_clk);
    end while (h !== 1'b1);
    i_rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
    logic [1:0] r;
    logic       ok;
    ok = (a == `SSCIE_ADDR_SET) || (a == `SSCIE_ADDR_CLR);
    axw(a, d, s, r);
    if (a == `SSCIE_ADDR_SET) m_mask = m_mask | (d & lanes(s));
    if (a == `SSCIE_ADDR_CLR) m_mask = m_mask & ~(d & lanes(s));
    chk("bresp", 32'(r), ok ? 32'h0 : 32'h2);
    chk_state();
  endtask : wr

  task automatic rd(input logic [31:0] a, input int exp_d, input int exp_r);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk("rdata", d, exp_d);
    chk("rresp", 32'(r), exp_r);
    if (a == `SSCIE_ADDR_STATUS) m_stat = 0;
    chk_state();
  endtask : rd

  // events are sampled at the edge that ends their cycle
  task automatic ev(input logic [11:0] e);
    i_src_events <= e;
    @(posedge i_ref_clk);
    i_src_events <= 12'h000;
    m_stat = m_stat | (e & 32'hf33);
    chk_state();
  endtask : ev

  int fld[8] = '{0, 1, 4, 5, 8, 9, 10, 11};

  initial begin
    i_ref_clk = 0; i_sys_rst = 1; i_awvalid = 0; i_wvalid = 0; i_bready = 0;
    i_arvalid = 0; i_rready = 0; i_awaddr = 0; i_wdata = 0; i_araddr = 0;
    i_wstrb = 0; i_src_events = 0;
    miscompares = 0; cmp_count = 0; cycles = 0; m_mask = 0; m_stat = 0;
    seed = 32'h82577c6e;
    repeat (8) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    chk_state();
    rd(`SSCIE_ADDR_MASK, 0, 0);
    $display("test reset done");

    foreach (fld[i]) begin
      wr(`SSCIE_ADDR_SET, 32'h0, 4'hf);
      wr(`SSCIE_ADDR_SET, 32'h1 << fld[i], 4'hf);
      rd(`SSCIE_ADDR_MASK, m_mask, 0);
    end
    foreach (fld[i]) begin
      wr(`SSCIE_ADDR_CLR, 32'h0, 4'hf);
      wr(`SSCIE_ADDR_CLR, 32'h1 << fld[i], 4'hf);
    end
    wr(`SSCIE_ADDR_SET, 32'hfffff0cc, 4'hf);
    $display("test per field set and clear done");

    wr(`SSCIE_ADDR_SET, 32'hffffffff, 4'hf);
    wr(`SSCIE_ADDR_MASK, 32'h0, 4'hf);
    wr(`SSCIE_ADDR_STATUS, 32'h0, 4'hf);
    wr(32'hf0010054, 32'h0, 4'hf);
    rd(`SSCIE_ADDR_SET, 0, 0);
    rd(`SSCIE_ADDR_CLR, 0, 0);
    rd(32'hf0010040, 0, 2);
    rd(`SSCIE_ADDR_MASK, m_mask, 0);
    $display("test refused accesses done");

    wr(`SSCIE_ADDR_CLR, 32'hffffffff, 4'hf);
    ev(12'hfff);
    foreach (fld[i]) begin
      wr(`SSCIE_ADDR_SET, 32'h1 << fld[i], 4'hf);
      wr(`SSCIE_ADDR_CLR, 32'h1 << fld[i], 4'hf);
    end
    wr(`SSCIE_ADDR_SET, 32'h20, 4'hf);
    rd(`SSCIE_ADDR_STATUS, 32'hf33, 0);
    ev(12'h020);
    $display("test interrupt output done");

    repeat (60) begin
      logic [31:0] r;
      r = xs();
      wr(r[0] ? `SSCIE_ADDR_SET : `SSCIE_ADDR_CLR, xs(), r[7:4]);
      if (r[8]) ev(r[27:16]);
      if (r[9]) rd(`SSCIE_ADDR_STATUS, m_stat, 0);
      if (r[10]) rd(`SSCIE_ADDR_MASK, m_mask, 0);
    end
    $display("test random traffic done");
    tally_and_finish();
  end
endmodule : test_ssc_interrupt_enable_control
